//--- video_dac_pkg.sv
`default_nettype none
package video_dac_pkg;

	// ==========================================
	// widths and codes
	localparam int PIXEL_W = 8;
	localparam logic [7:0] CODE_FULL_SCALE = 8'hff;
	localparam logic [7:0] CODE_ZERO = 8'h00;

	// ==========================================
	// timing
	localparam int CLK_RATE_MHZ = 20;
	localparam int MAX_PIXEL_RATE_MHZ = 75;

	// ==========================================
	// pedestal (black-to-blank offset) encodings
	typedef enum logic [2:0] {
		PED_10_IRE = 3'b001,
		PED_7_IRE = 3'b010,
		PED_0_IRE = 3'b100
	} pedestal_t;

	// ==========================================
	// captured pixel and control set (controls active low)
	typedef struct packed {
		logic [7:0] pixel_code;
		logic blanking_force_n;
		logic composite_timing_pulse_n;
		logic force_full_scale_n;
		logic extra_bright_n;
	} pixel_set_t;

	// converter drive word
	typedef struct packed {
		logic [7:0] dac_code;
		logic data_en;
		logic pedestal_10_en;
		logic pedestal_7_en;
		logic timing_pulse_en;
		logic overbright_en;
	} dac_drive_t;

endpackage
`default_nettype wire

//--- pixel_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_skid_buffer
	import video_dac_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input var pixel_set_t in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output pixel_set_t out_data_o
);

	typedef struct packed {
		pixel_set_t [1:0] mem;
		logic [1:0] count;
		logic rd;
		logic wr;
	} buf_state_t;

	buf_state_t st_reg;
	buf_state_t st_next;
	logic push;
	logic pop;

	// ==========================================
	// two-entry fifo
	always_comb begin
		st_next = st_reg;
		push = in_valid_i && (st_reg.count != 2'd2);
		pop = out_ready_i && (st_reg.count != 2'd0);
		if (push) begin
			st_next.mem[st_reg.wr] = in_data_i;
			st_next.wr = ~st_reg.wr;
		end
		if (pop) begin
			st_next.rd = ~st_reg.rd;
		end
		st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign in_ready_o = (st_reg.count != 2'd2);
	assign out_valid_o = (st_reg.count != 2'd0);
	assign out_data_o = st_reg.mem[st_reg.rd];

endmodule
`default_nettype wire

//--- video_dac_input_pipeline.sv
`timescale 1ns/1ps
`default_nettype none
module video_dac_input_pipeline
	import video_dac_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// pixel and video controls from the controller
	input wire logic [7:0] pixel_code_i,
	input wire logic blanking_force_n_i,
	input wire logic composite_timing_pulse_n_i,
	input wire logic force_full_scale_n_i,
	input wire logic extra_bright_n_i,
	input wire logic pixel_valid_i,
	output logic pixel_ready_o,
	// static pedestal configuration
	input wire logic [2:0] pedestal_select_i,
	// converter drive
	input wire logic dac_ready_i,
	output logic dac_valid_o,
	output logic [7:0] dac_code_o,
	output logic data_en_o,
	output logic pedestal_10_en_o,
	output logic pedestal_7_en_o,
	output logic timing_pulse_en_o,
	output logic overbright_en_o
);

	// ==========================================
	// state
	typedef struct packed {
		pixel_set_t [1:0] in_sync;
		logic [1:0] vld_sync;
		logic [1:0][2:0] ped_sync;
		pixel_set_t cap;
		logic cap_valid;
		dac_drive_t drive;
		logic drive_valid;
		logic ready;
	} pipe_state_t;

	pipe_state_t st_reg;
	pipe_state_t st_next;
	pixel_set_t in_set;
	pixel_set_t buf_data;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_take;
	dac_drive_t drive_c;
	pedestal_t ped;

	always_comb begin
		in_set.pixel_code = pixel_code_i;
		in_set.blanking_force_n = blanking_force_n_i;
		in_set.composite_timing_pulse_n = composite_timing_pulse_n_i;
		in_set.force_full_scale_n = force_full_scale_n_i;
		in_set.extra_bright_n = extra_bright_n_i;
	end

	// ==========================================
	// two-entry buffer between capture and drive
	pixel_skid_buffer u_buf (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(st_reg.cap_valid),
		.in_ready_o(buf_in_ready),
		.in_data_i(st_reg.cap),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_take),
		.out_data_o(buf_data)
	);

	assign buf_take = dac_ready_i || !st_reg.drive_valid;

	// ==========================================
	// output decode
	always_comb begin
		drive_c = '0;
		ped = pedestal_t'(st_reg.ped_sync[1]);
		drive_c.dac_code = buf_data.pixel_code;
		if (!buf_data.force_full_scale_n) begin
			drive_c.dac_code = CODE_FULL_SCALE;
		end
		drive_c.data_en = 1'b1;
		drive_c.overbright_en = !buf_data.extra_bright_n;
		drive_c.pedestal_10_en = (ped == PED_10_IRE);
		drive_c.pedestal_7_en = (ped == PED_7_IRE);
		if (!buf_data.blanking_force_n) begin
			drive_c.dac_code = CODE_ZERO;
			drive_c.data_en = 1'b0;
			drive_c.overbright_en = 1'b0;
			drive_c.pedestal_10_en = 1'b0;
			drive_c.pedestal_7_en = 1'b0;
		end
		// pulse only removes its own source
		drive_c.timing_pulse_en = buf_data.composite_timing_pulse_n;
	end

	// ==========================================
	// pipeline registers
	always_comb begin
		st_next = st_reg;
		st_next.in_sync[0] = in_set;
		st_next.in_sync[1] = st_reg.in_sync[0];
		st_next.vld_sync[0] = pixel_valid_i;
		st_next.vld_sync[1] = st_reg.vld_sync[0];
		st_next.ped_sync[0] = pedestal_select_i;
		st_next.ped_sync[1] = st_reg.ped_sync[0];
		st_next.ready = buf_in_ready;
		// all fields captured together each edge
		st_next.cap = st_reg.in_sync[1];
		st_next.cap_valid = st_reg.vld_sync[1] && buf_in_ready;
		if (buf_take) begin
			st_next.drive = drive_c;
			st_next.drive_valid = buf_out_valid;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.in_sync[0].blanking_force_n <= 1'b1;
			st_reg.in_sync[1].blanking_force_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// outputs
	assign pixel_ready_o = st_reg.ready;
	assign dac_valid_o = st_reg.drive_valid;
	assign dac_code_o = st_reg.drive.dac_code;
	assign data_en_o = st_reg.drive.data_en;
	assign pedestal_10_en_o = st_reg.drive.pedestal_10_en;
	assign pedestal_7_en_o = st_reg.drive.pedestal_7_en;
	assign timing_pulse_en_o = st_reg.drive.timing_pulse_en;
	assign overbright_en_o = st_reg.drive.overbright_en;

endmodule
`default_nettype wire

//--- pixel_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// controller model
module pixel_source
	import video_dac_pkg::*;
(
	input wire logic clk_i,
	output var pixel_set_t set_o,
	output logic valid_o
);
	initial begin
		set_o = '1;
		valid_o = 1'b0;
	end
	task automatic send(input pixel_set_t s);
		@(posedge clk_i);
		#2;
		s.composite_timing_pulse_n |= s.blanking_force_n;
		set_o = s;
		valid_o = 1'b1;
	endtask
	task automatic idle();
		@(posedge clk_i);
		#2;
		valid_o = 1'b0;
		set_o = ~set_o;
	endtask
endmodule
`default_nettype wire

//--- dac_pipe_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// output checks
module dac_pipe_monitor (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic pixel_valid_i,
	input wire logic force_full_scale_n_i,
	input wire logic blanking_force_n_i,
	input wire logic dac_ready_i,
	input wire logic dac_valid_o,
	input wire logic [7:0] dac_code_o,
	input wire logic data_en_o,
	input wire logic pedestal_10_en_o,
	input wire logic pedestal_7_en_o,
	input wire logic overbright_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_reset_idle: assert property ($fell(sys_rst_i) |-> !dac_valid_o)
		else $error("valid after reset");
	a_blank_level: assert property (dac_valid_o && !data_en_o |->
		dac_code_o == 8'h00 && !overbright_en_o) else $error("blank level");
	a_blank_offset: assert property (dac_valid_o && !data_en_o |->
		!pedestal_10_en_o && !pedestal_7_en_o) else $error("blank offset");
	a_offset_one: assert property (dac_valid_o |->
		!(pedestal_10_en_o && pedestal_7_en_o)) else $error("two offsets");
	a_word_hold: assert property (dac_valid_o && !dac_ready_i |=>
		dac_valid_o && $stable(dac_code_o) && $stable(data_en_o))
		else $error("word not held");
	a_bright_data: assert property (dac_valid_o && overbright_en_o |->
		data_en_o) else $error("overbright in blank");
	a_full_latency: assert property ((dac_ready_i && !pixel_valid_i)[*6]
		##1 (pixel_valid_i && !force_full_scale_n_i && blanking_force_n_i)
		##1 dac_ready_i[*4] |=> dac_valid_o && dac_code_o == 8'hff)
		else $error("full scale word late or wrong");
	a_drain_idle: assert property ((dac_ready_i && !pixel_valid_i)[*8]
		|-> !dac_valid_o) else $error("word from nowhere");
endmodule
bind video_dac_input_pipeline dac_pipe_monitor mon (.clk_i, .sys_rst_i,
	.pixel_valid_i, .force_full_scale_n_i, .blanking_force_n_i, .dac_ready_i,
	.dac_valid_o, .dac_code_o, .data_en_o, .pedestal_10_en_o,
	.pedestal_7_en_o, .overbright_en_o);
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module tb_top;
	import video_dac_pkg::*;
	logic clk_i = 0;
	logic sys_rst_i = 1;
	logic dac_ready_i = 1;
	logic [2:0] sel = 3'h1;
	logic pv, pixel_ready_o, dac_valid_o, data_en_o, pedestal_10_en_o;
	logic pedestal_7_en_o, timing_pulse_en_o, overbright_en_o;
	logic [7:0] dac_code_o;
	pixel_set_t px;
	dac_drive_t got[$], exp[$];
	int n_mismatch = 0, checks = 0;
	pixel_set_t tbl[6] = '{12'h12d, 12'h01f, 12'h80e, 12'h00f, 12'h5a4, 12'hff3};
	always #25 clk_i = ~clk_i;
	pixel_source src (.clk_i, .set_o(px), .valid_o(pv));
	video_dac_input_pipeline dut (.clk_i, .sys_rst_i,
		.pixel_code_i(px.pixel_code), .blanking_force_n_i(px.blanking_force_n),
		.composite_timing_pulse_n_i(px.composite_timing_pulse_n),
		.force_full_scale_n_i(px.force_full_scale_n),
		.extra_bright_n_i(px.extra_bright_n), .pixel_valid_i(pv),
		.pixel_ready_o, .pedestal_select_i(sel), .dac_ready_i, .dac_valid_o,
		.dac_code_o, .data_en_o, .pedestal_10_en_o, .pedestal_7_en_o,
		.timing_pulse_en_o, .overbright_en_o);
	always @(posedge clk_i) if (dac_valid_o && dac_ready_i)
		got.push_back({dac_code_o, data_en_o, pedestal_10_en_o,
			pedestal_7_en_o, timing_pulse_en_o, overbright_en_o});
	function automatic dac_drive_t model(pixel_set_t s, logic [2:0] p);
		dac_drive_t d;
		d = '0;
		d.timing_pulse_en = s.composite_timing_pulse_n;
		if (s.blanking_force_n) begin
			d.dac_code = s.force_full_scale_n ? s.pixel_code : 8'hff;
			d.data_en = 1'b1;
			d.pedestal_10_en = p == PED_10_IRE;
			d.pedestal_7_en = p == PED_7_IRE;
			d.overbright_en = !s.extra_bright_n;
		end
		return d;
	endfunction
	task test_done();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(string n, logic [12:0] e, logic [12:0] g);
		checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task put(pixel_set_t s);
		src.send(s);
		exp.push_back(model(src.set_o, sel));
	endtask
	task drain();
		for (int i = 0; i < 40 && got.size() < exp.size(); i++)
			@(posedge clk_i);
		if (got.size() != exp.size()) begin
			chk("word count", exp.size(), got.size());
			test_done();
		end
		foreach (exp[k]) chk("drive word", exp[k], got[k]);
		exp = {};
		got = {};
	endtask
	task run_stream(logic [2:0] p);
		@(posedge clk_i);
		#2;
		sel = p;
		repeat (8) @(posedge clk_i);
		foreach (tbl[i]) put(tbl[i]);
		src.idle();
		drain();
	endtask
	task run_stall();
		#2;
		dac_ready_i = 0;
		put(tbl[2]);
		put(tbl[1]);
		put(tbl[4]);
		src.idle();
		repeat (8) @(posedge clk_i);
		#2;
		chk("pixel ready", 1'h0, pixel_ready_o);
		dac_ready_i = 1;
		drain();
		#2;
		chk("pixel ready", 1'h1, pixel_ready_o);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		#2;
		sys_rst_i = 0;
		run_stream(PED_10_IRE);
		run_stream(PED_7_IRE);
		run_stream(3'h3);
		run_stream(PED_0_IRE);
		run_stall();
		test_done();
	end
endmodule
`default_nettype wire
